//--- rtl/stp_defs.vh
// Constants for the shared timer prescaler.
// Assumes inclusion by bare name from rtl modules; definitions only.
`ifndef STP_DEFS_VH
`define STP_DEFS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define STP_ADDR_W 4
`define STP_OFS_SYNC_CTRL 4'h0
`define STP_OFS_TICK_SEL 4'h1
`define STP_BIT_HOLD 7
`define STP_BIT_DIVRST 0
`define STP_SYNC_CTRL_RST 8'h00
`define STP_TICK_SEL_RST 8'h00

// ----------------------------------------
// Tick source codes
// ----------------------------------------
`define STP_SEL_STOP 3'h0
`define STP_SEL_DIRECT 3'h1
`define STP_SEL_DIV8 3'h2
`define STP_SEL_DIV64 3'h3
`define STP_SEL_DIV256 3'h4
`define STP_SEL_DIV1024 3'h5
`define STP_SEL_EXT_FALL 3'h6
`define STP_SEL_EXT_RISE 3'h7

// ----------------------------------------
// Divider taps (terminal counts)
// ----------------------------------------
`define STP_DIV_W 10
`define STP_TAP8_MASK 10'h007
`define STP_TAP64_MASK 10'h03F
`define STP_TAP256_MASK 10'h0FF
`define STP_TAP1024_MASK 10'h3FF

`endif

//--- rtl/stp_pin_sync.v
// External count pin synchroniser and edge detector.
// Assumes one clock; pin is asynchronous to it.
`include "stp_defs.vh"

module stp_pin_sync (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Pin
  input wire external_count_pin,
  // Edge outputs
  output wire rise_pulse,
  output wire fall_pulse
);

  reg latch_ff;
  reg sync_ff;
  reg hist_ff;

  // ----------------------------------------
  // Sample stage then compare stage
  // ----------------------------------------
  // Latch transparent in clock-high phase modelled as a first flop stage
  always @(posedge clk) begin
    if (!rstn) begin
      latch_ff <= 1'b0;
      sync_ff <= 1'b0;
      hist_ff <= 1'b0;
    end else begin
      latch_ff <= external_count_pin;
      sync_ff <= latch_ff;
      hist_ff <= sync_ff;
    end
  end

  assign rise_pulse = sync_ff & ~hist_ff;
  assign fall_pulse = ~sync_ff & hist_ff;

endmodule // stp_pin_sync

//--- rtl/stp_prescaler.v
// Shared timer prescaler: one free-running divider, two tick selectors.
// Assumes a simple strobe register port; count pins may be asynchronous.
//
// The register offsets and the strobed register port were chosen for this implementation.
`include "stp_defs.vh"

module stp_prescaler (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  // External count pins, timer 0 and timer 1
  input wire external_count_pin0,
  input wire external_count_pin1,
  // Count ticks to the timers
  output wire tick0,
  output wire tick1,
  // Divider held in reset
  output wire timers_halted
);

  reg [`STP_DIV_W-1:0] div_ff;
  reg sync_hold_mode_ff;
  reg divider_reset_bit_ff;
  reg [2:0] tick_source_select0_ff;
  reg [2:0] tick_source_select1_ff;
  reg [7:0] rdata_ff;
  reg nxt_hold;
  reg nxt_divrst;
  wire rise0, fall0, rise1, fall1;
  wire wr_sync;
  wire [`STP_DIV_W-1:0] nxt_div;

  // ----------------------------------------
  // Tap selection function
  // ----------------------------------------
  function tap_tick;
    input [2:0] sel;
    input [`STP_DIV_W-1:0] cnt;
    input rise;
    input fall;
    input halted;
    begin
      case (sel)
        `STP_SEL_STOP: tap_tick = 1'b0;
        `STP_SEL_DIRECT: tap_tick = ~halted;
        `STP_SEL_DIV8:
          tap_tick = ~halted & ((cnt & `STP_TAP8_MASK) == `STP_TAP8_MASK);
        `STP_SEL_DIV64:
          tap_tick = ~halted & ((cnt & `STP_TAP64_MASK) == `STP_TAP64_MASK);
        `STP_SEL_DIV256:
          tap_tick = ~halted & ((cnt & `STP_TAP256_MASK) == `STP_TAP256_MASK);
        `STP_SEL_DIV1024:
          tap_tick = ~halted & (cnt == `STP_TAP1024_MASK);
        `STP_SEL_EXT_FALL: tap_tick = fall;
        `STP_SEL_EXT_RISE: tap_tick = rise;
        default: tap_tick = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  stp_pin_sync u_sync0 (
    .clk(clk),
    .rstn(rstn),
    .external_count_pin(external_count_pin0),
    .rise_pulse(rise0),
    .fall_pulse(fall0)
  );

  stp_pin_sync u_sync1 (
    .clk(clk),
    .rstn(rstn),
    .external_count_pin(external_count_pin1),
    .rise_pulse(rise1),
    .fall_pulse(fall1)
  );

  // ----------------------------------------
  // Shared divider
  // ----------------------------------------
  assign nxt_div = div_ff + 10'h001;

  always @(posedge clk) begin
    if (!rstn) begin
      div_ff <= {`STP_DIV_W{1'b0}};
    end else if (divider_reset_bit_ff) begin
      div_ff <= {`STP_DIV_W{1'b0}};
    end else begin
      div_ff <= nxt_div;
    end
  end

  assign timers_halted = divider_reset_bit_ff;
  // Both timers see one divider, so one reset restarts both periods
  assign tick0 = tap_tick(tick_source_select0_ff, div_ff, rise0, fall0,
                          divider_reset_bit_ff);
  assign tick1 = tap_tick(tick_source_select1_ff, div_ff, rise1, fall1,
                          divider_reset_bit_ff);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  assign wr_sync = reg_wr & (reg_addr == `STP_OFS_SYNC_CTRL);

  always @* begin
    nxt_hold = sync_hold_mode_ff;
    nxt_divrst = divider_reset_bit_ff;
    if (wr_sync) begin
      nxt_hold = reg_wdata[`STP_BIT_HOLD];
      nxt_divrst = reg_wdata[`STP_BIT_DIVRST] & reg_wdata[`STP_BIT_HOLD];
      if (reg_wdata[`STP_BIT_DIVRST] & ~reg_wdata[`STP_BIT_HOLD]) begin
        nxt_divrst = 1'b1;
      end
    end else if (!sync_hold_mode_ff) begin
      nxt_divrst = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      sync_hold_mode_ff <= 1'b0;
      divider_reset_bit_ff <= 1'b0;
      tick_source_select0_ff <= 3'h0;
      tick_source_select1_ff <= 3'h0;
    end else begin
      sync_hold_mode_ff <= nxt_hold;
      divider_reset_bit_ff <= nxt_divrst;
      if (reg_wr && reg_addr == `STP_OFS_TICK_SEL) begin
        tick_source_select0_ff <= reg_wdata[2:0];
        tick_source_select1_ff <= reg_wdata[6:4];
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `STP_OFS_SYNC_CTRL:
          rdata_ff <= {sync_hold_mode_ff, 6'h00, divider_reset_bit_ff};
        `STP_OFS_TICK_SEL:
          rdata_ff <= {1'b0, tick_source_select1_ff, 1'b0, tick_source_select0_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule // stp_prescaler

//--- dv/stp_checker.sv
// Port checker for the shared timer prescaler.
// Assumes bind to stp_prescaler; one clock, sync reset.
module stp_checker (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Timer 0 side
  input wire external_count_pin0,
  input wire tick0,
  input wire timers_halted
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [2:0] s0_ff;
  reg hold_ff;
  wire w0 = reg_wr && reg_addr == 4'h0;
  always @(posedge clk) begin
    if (!rstn) begin
      s0_ff <= 3'h0;
      hold_ff <= 1'h0;
    end else begin
      if (reg_wr && reg_addr == 4'h1) s0_ff <= reg_wdata[2:0];
      if (w0) hold_ff <= reg_wdata[7];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_rb;
    reg_rd && reg_addr == 4'h0 |=> reg_rdata == {$past(hold_ff), 6'h00, $past(timers_halted)};
  endproperty
  property p_dir; s0_ff == 3'h1 && !timers_halted |-> tick0; endproperty
  property p_stop; s0_ff == 3'h0 |-> !tick0; endproperty
  property p_halt; timers_halted && s0_ff inside {[3'h1:3'h5]} |-> !tick0; endproperty
  property p_clr; w0 && reg_wdata == 8'h01 |=> timers_halted ##1 !timers_halted; endproperty
  property p_rel; w0 && !reg_wdata[7] && !reg_wdata[0] |=> !timers_halted; endproperty
  property p_ext; s0_ff == 3'h7 && $rose(external_count_pin0) |-> ##[2:3] tick0; endproperty
  // No write in the tick cycle either, so the select and divider phase hold
  property p_div8; tick0 && s0_ff == 3'h2 && !reg_wr ##1 (!reg_wr) [*8] |-> tick0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_rb: assert property (p_rb) else $error("control readback wrong");
  a_dir: assert property (p_dir) else $error("direct tick missing");
  a_stop: assert property (p_stop) else $error("stopped timer ticked");
  a_halt: assert property (p_halt) else $error("tick while halted");
  a_clr: assert property (p_clr) else $error("reset bit not pulsed");
  a_rel: assert property (p_rel) else $error("halt not released");
  a_ext: assert property (p_ext) else $error("pin tick late");
  a_div8: assert property (p_div8) else $error("divide by 8 period");
  c_hold: cover property (timers_halted && hold_ff);
  c_ext: cover property (s0_ff == 3'h7 && tick0);
  c_div: cover property (s0_ff == 3'h2 && tick0);
endmodule // stp_checker

bind stp_prescaler stp_checker u_chk (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .external_count_pin0, .tick0, .timers_halted);

//--- dv/stp_timer_model.sv
// Two timer counters consuming the prescaler ticks.
// Assumes ticks are one-cycle pulses on clk.
module stp_timer_model (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Ticks in, counts out
  input wire tick0,
  input wire tick1,
  output logic [15:0] cnt0_ff,
  output logic [15:0] cnt1_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    if (!rstn) begin
      cnt0_ff <= 16'h0000;
      cnt1_ff <= 16'h0000;
    end else begin
      cnt0_ff <= cnt0_ff + {15'h0000, tick0};
      cnt1_ff <= cnt1_ff + {15'h0000, tick1};
    end
  end
endmodule // stp_timer_model

//--- dv/tb_shared_timer_prescaler.sv
// Self-checking bench for the shared timer prescaler.
// Assumes the timer model counts ticks; checker is bound.
module tb_shared_timer_prescaler;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin0 = 1'b0;
  logic pin1 = 1'b0;
  wire [7:0] reg_rdata;
  wire tick0, tick1, halted;
  wire [15:0] cnt0_ff, cnt1_ff;
  logic [15:0] b0, b1;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  stp_prescaler DUT (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .external_count_pin0(pin0), .external_count_pin1(pin1), .tick0, .tick1,
    .timers_halted(halted));
  stp_timer_model u_tmr (.clk, .rstn, .tick0, .tick1, .cnt0_ff, .cnt1_ff);
  initial forever #5 clk = ~clk;
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
  endtask
  // Tick counts over a window of n cycles
  task automatic win(int n, logic [15:0] e0, logic [15:0] e1);
    #1 b0 = cnt0_ff;
    b1 = cnt1_ff;
    repeat (n) @(posedge clk);
    #1 chk("ticks0", cnt0_ff - b0, e0);
    chk("ticks1", cnt1_ff - b1, e1);
  endtask
  task automatic t_regs;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h81);
    rd(4'h0, 8'h81);
    wr(4'h0, 8'h7E);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h00);
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00);
  endtask
  task automatic t_tap(logic [7:0] s, int n, logic [15:0] e0, logic [15:0] e1);
    wr(4'h1, s);
    win(n, e0, e1);
  endtask
  task automatic t_hold;
    wr(4'h1, 8'h11);
    wr(4'h0, 8'h81);
    win(20, 16'h0000, 16'h0000);
    wr(4'h0, 8'h00);
    win(16, 16'h0010, 16'h0010);
  endtask
  // Divider reset pulse restarts both div8 periods
  task automatic t_sync;
    wr(4'h1, 8'h22);
    wr(4'h0, 8'h01);
    #1 chk("halted", {15'h0000, halted}, 16'h0001);
    win(8, 16'h0000, 16'h0000);
    win(1, 16'h0001, 16'h0001);
  endtask
  task automatic t_ext;
    wr(4'h1, 8'h67);
    #1 b0 = cnt0_ff;
    b1 = cnt1_ff;
    @(posedge clk);
    repeat (5) begin
      pin0 <= 1'b1;
      pin1 <= 1'b1;
      repeat (4) @(posedge clk);
      pin0 <= 1'b0;
      pin1 <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1 chk("rise_ticks", cnt0_ff - b0, 16'h0005);
    chk("fall_ticks", cnt1_ff - b1, 16'h0005);
    wr(4'h1, 8'h00);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_tap(8'h12, 64, 16'h0008, 16'h0040);
    t_tap(8'h53, 2048, 16'h0020, 16'h0002);
    t_tap(8'h04, 512, 16'h0002, 16'h0000);
    t_hold;
    t_sync;
    t_ext;
    close_out;
  end
endmodule // tb_shared_timer_prescaler
